// ### core/psr_pkg.sv
package psr_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned TICK_W = 18;
	// register offsets
	localparam logic [7:0] SYS_CTRL2_ADDR = 8'h05;
	localparam logic [7:0] HOLD_ADDR = 8'h19;
	localparam logic [7:0] SS_ADDR = 8'h1a;
	localparam logic [7:0] TRIM_ADDR = 8'h1b;
	localparam logic [7:0] BKND_ADDR = 8'h1c;
	// field positions
	localparam int unsigned SYS_SD_BIT = 6;
	localparam int unsigned SS_DIS_BIT = 7;
	localparam int unsigned TRIM_DONE_BIT = 6;
	localparam int unsigned TRIM_SEL_BIT = 1;
	// reset values, software hold-group values, trim start and read constants
	localparam logic SYS_SD_RST = 1'h1;
	localparam logic [7:0] HOLD_RST = 8'h30;
	localparam logic [7:0] HOLD_BTL = 8'h30;
	localparam logic [7:0] HOLD_PARALLEL_BRIDGE_OUTPUT = 8'h3a;
	localparam logic [7:0] SS_RST = 8'h0f;
	localparam logic [3:0] BK_RST = 4'h2;
	localparam logic [7:0] TRIM_START = 8'h00;
	localparam logic [7:0] TRIM_RD_BASE = 8'h80;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	// period codes
	localparam logic [4:0] SS_FIRST_CODE = 5'h08;
	localparam logic [3:0] BK_FIRST_CODE = 4'h2;
	// timing: periods count in ticks of 0.1 ms
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned TICK_NS = 100000;
	localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned TRIM_TIME_NS = 2000;
	localparam int unsigned TRIM_CYCLES =
		(TRIM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_SHUT = 3'h0,
		ST_RAMP_UP = 3'h1,
		ST_RUN = 3'h3,
		ST_RAMP_DN = 3'h2,
		ST_FAULT = 3'h6
	} psr_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [DATA_W-1:0] wdata;
	} psr_reg_req_t;

	typedef struct packed {
		logic [NUM_CH-1:0] ch_run;
		logic duty_hold;
		logic pwm_halt;
		logic stage_reset;
	} psr_stage_t;

	// soft start/stop hold length in ticks
	function automatic logic [TICK_W-1:0] psr_ss_ticks(input logic [4:0] c);
		logic [TICK_W-1:0] t;
		t = 18'h0;
		case (c)
			5'h08: t = 18'd165;
			5'h09: t = 18'd239;
			5'h0a: t = 18'd314;
			5'h0b: t = 18'd404;
			5'h0c: t = 18'd539;
			5'h0d: t = 18'd703;
			5'h0e: t = 18'd942;
			5'h0f: t = 18'd1257;
			5'h10: t = 18'd1646;
			5'h11: t = 18'd2394;
			5'h12: t = 18'd3142;
			5'h13: t = 18'd4039;
			5'h14: t = 18'd5386;
			5'h15: t = 18'd7031;
			5'h16: t = 18'd9425;
			5'h17: t = 18'd12566;
			5'h18: t = 18'd17281;
			5'h19: t = 18'd25136;
			5'h1a: t = 18'd32991;
			5'h1b: t = 18'd42417;
			5'h1c: t = 18'd56556;
			5'h1d: t = 18'd73837;
			5'h1e: t = 18'd98973;
			5'h1f: t = 18'd131964;
			default: t = 18'h0;
		endcase
		return t;
	endfunction

	// back-end recovery wait in ticks
	function automatic logic [TICK_W-1:0] psr_bk_ticks(input logic [3:0] c);
		logic [TICK_W-1:0] t;
		t = 18'd14960;
		case (c)
			4'h3: t = 18'd4490;
			4'h4: t = 18'd5980;
			4'h5: t = 18'd7480;
			4'h6: t = 18'd8980;
			4'h7: t = 18'd10470;
			4'h8: t = 18'd11970;
			4'h9: t = 18'd13460;
			4'h0, 4'h1, 4'h2: t = 18'd2990;
			default: t = 18'd14960;
		endcase
		return t;
	endfunction
endpackage

// ### core/psr_seq.sv
// Notes on behaviour
// - hold-group bits 0..3 mark channels 1..4 as members; zero means not held
// - leaving shutdown starts only channels whose hold-group bit is clear
// - hold-group resets to 0x30; software uses 0x30 bridged, 0x3a paralleled
// - start/stop period follows shutdown entry, exit and power-down pin change
// - period bits 4:3 equal 00 means no 50% duty hold interval
// - code 01000..11111 selects 16.5 ms..13196.4 ms; default 01111 is 125.7 ms
// - interval lengths are whole ticks; tick phase restarts at each state change
// - internal oscillator trim supports rate detection without external ref
// - writing 0x00 to trim register applies factory trim and starts trim
// - trim bit 1 written 0 selects factory trim; resets to 1
// - trim bit 6 is read-only; 0 until trim finished, then 1
// - back-end error resets power stage and halts all PWM switching; the code ignores it while in shutdown
// - after the halt, wait the recovery period then restart the stage
// - recovery code 0010 is 299 ms default, rising to 1346 ms, then 1496 ms
// - recovery register accepts one write per device reset
// - system control bit 6 set enters shutdown; clearing it commands exit
`timescale 1ns/100ps
`default_nettype none
module psr_seq
	import psr_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYCLES,
	parameter int unsigned TRIM_CYC = TRIM_CYCLES
) (
	input wire logic core_clk_i, // 125 MHz core clock
	input wire logic sys_rst_i, // synchronous reset, active high
	input wire psr_pkg::psr_reg_req_t reg_req_i, // register access strobes
	output logic [psr_pkg::DATA_W-1:0] reg_rdata_o, // read data, registered
	input wire logic power_down_pin_i, // power-down pin level, high = down
	input wire logic backend_fault_i, // back-end error from power stage
	output psr_pkg::psr_stage_t stage_o, // channel run and stage control
	output logic osc_factory_trim_o, // factory oscillator trim applied
	output logic osc_trim_done_o // oscillator trim finished
);
	import psr_pkg::*;

	localparam int unsigned PRESC_W = $clog2(TICK_CYC + 1);
	localparam int unsigned TRIM_W = $clog2(TRIM_CYC + 1);
	localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYC - 1);
	localparam logic [TRIM_W-1:0] TRIM_LAST = TRIM_W'(TRIM_CYC - 1);

	generate
		if (TICK_CYC < 1 || TRIM_CYC < 1) begin : g_bad_param
			$error("psr_seq: cycle counts must be at least one");
		end
	endgenerate

	logic sys_sd_q;
	logic [DATA_W-1:0] hold_q;
	logic [DATA_W-1:0] ss_q;
	logic trim_sel_q;
	logic trim_done_q;
	logic trim_busy_q;
	logic [TRIM_W-1:0] trim_cnt_q;
	logic [3:0] bk_code_q;
	logic bk_written_q;
	logic pin_q;
	psr_state_t state_q, state_d;
	logic [TICK_W-1:0] remain_q, load_d;
	logic [PRESC_W-1:0] presc_q;
	logic [NUM_CH-1:0] run_mask_q;
	logic [NUM_CH-1:0] ch_run_q;
	logic duty_hold_q, pwm_halt_q, stage_reset_q;
	logic mask_take, run_next;
	logic [DATA_W-1:0] rdata_q;
	logic tick, sd_req, pin_change, ss_zero, bk_ok, trans;
	logic wr_hold, wr_ss, wr_trim, wr_bk, wr_sys;

	assign wr_sys = reg_req_i.wr && reg_req_i.addr == SYS_CTRL2_ADDR;
	assign wr_hold = reg_req_i.wr && reg_req_i.addr == HOLD_ADDR;
	assign wr_ss = reg_req_i.wr && reg_req_i.addr == SS_ADDR;
	assign wr_trim = reg_req_i.wr && reg_req_i.addr == TRIM_ADDR;
	assign wr_bk = reg_req_i.wr && reg_req_i.addr == BKND_ADDR;

	// shutdown command bit of system control register 2
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			sys_sd_q <= SYS_SD_RST;
		end else if (wr_sys) begin
			sys_sd_q <= reg_req_i.wdata[SYS_SD_BIT];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			hold_q <= HOLD_RST;
		end else if (wr_hold) begin
			hold_q <= reg_req_i.wdata;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ss_q <= SS_RST;
		end else if (wr_ss) begin
			ss_q <= reg_req_i.wdata;
		end
	end

	// oscillator trim engine; the core clock stands in as the oscillator
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			trim_sel_q <= 1'b1;
			trim_done_q <= 1'b0;
			trim_busy_q <= 1'b0;
			trim_cnt_q <= '0;
		end else if (wr_trim) begin
			trim_sel_q <= reg_req_i.wdata[TRIM_SEL_BIT];
			trim_busy_q <= !reg_req_i.wdata[TRIM_SEL_BIT];
			trim_done_q <= 1'b0;
			trim_cnt_q <= '0;
		end else if (trim_busy_q) begin
			if (trim_cnt_q == TRIM_LAST) begin
				trim_busy_q <= 1'b0;
				trim_done_q <= 1'b1;
			end else begin
				trim_cnt_q <= trim_cnt_q + 1'b1;
			end
		end
	end

	// reserved codes are dropped without using up the single write
	assign bk_ok = reg_req_i.wdata[7:4] == 4'h0 &&
		reg_req_i.wdata[3:0] >= BK_FIRST_CODE;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bk_code_q <= BK_RST;
			bk_written_q <= 1'b0;
		end else if (wr_bk && !bk_written_q && bk_ok) begin
			bk_code_q <= reg_req_i.wdata[3:0];
			bk_written_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= UNMAPPED_RD;
		end else if (reg_req_i.rd) begin
			unique case (reg_req_i.addr)
				SYS_CTRL2_ADDR: rdata_q <= DATA_W'(sys_sd_q) << SYS_SD_BIT;
				HOLD_ADDR: rdata_q <= hold_q;
				SS_ADDR: rdata_q <= ss_q;
				TRIM_ADDR: rdata_q <= TRIM_RD_BASE |
					(DATA_W'(trim_done_q) << TRIM_DONE_BIT) |
					(DATA_W'(trim_sel_q) << TRIM_SEL_BIT);
				BKND_ADDR: rdata_q <= {4'h0, bk_code_q};
				default: rdata_q <= UNMAPPED_RD;
			endcase
		end
	end
	assign reg_rdata_o = rdata_q;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= power_down_pin_i;
		end
	end

	// pin edge; a rising edge while running starts the stop ramp
	assign pin_change = pin_q != power_down_pin_i;
	assign sd_req = sys_sd_q || power_down_pin_i;
	assign ss_zero = ss_q[SS_DIS_BIT] || ss_q[4:3] == 2'b00;

	// 0.1 ms tick; prescaler restarts on each state change, so first tick lands a full tick later
	assign tick = presc_q == PRESC_LAST;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || trans || tick) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 1'b1;
		end
	end

	always_comb begin
		state_d = state_q;
		load_d = '0;
		unique case (state_q)
			ST_SHUT: begin
				if (!sd_req) begin
					state_d = ST_RAMP_UP;
				end
			end
			ST_RAMP_UP: begin
				if (sd_req) begin
					state_d = ST_RAMP_DN;
				end else if (remain_q == '0) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sd_req) begin
					state_d = ST_RAMP_DN;
				end
			end
			ST_RAMP_DN: begin
				if (remain_q == '0) begin
					state_d = ST_SHUT;
				end
			end
			ST_FAULT: begin
				if (sd_req) begin
					state_d = ST_SHUT;
				end else if (remain_q == '0) begin
					state_d = ST_RAMP_UP;
				end
			end
			default: state_d = ST_SHUT;
		endcase
		if (backend_fault_i && state_q != ST_SHUT) begin
			state_d = ST_FAULT;
		end
		if (state_d == ST_FAULT) begin
			load_d = psr_bk_ticks(bk_code_q);
		end else if (!ss_zero) begin
			load_d = psr_ss_ticks(ss_q[4:0]);
		end
	end

	assign trans = state_d != state_q ||
		(state_q == ST_FAULT && backend_fault_i);

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_q <= ST_SHUT;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			remain_q <= '0;
		end else if (trans) begin
			remain_q <= load_d;
		end else if (tick && remain_q != '0) begin
			remain_q <= remain_q - 1'b1;
		end
	end

	// channel start mask is caught at the shutdown exit; the outputs use
	// the freshly caught mask so the first ramp cycle already shows it
	assign mask_take = state_q == ST_SHUT && !sd_req;
	assign run_next = state_d == ST_RAMP_UP || state_d == ST_RUN ||
		state_d == ST_RAMP_DN;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			always_ff @(posedge core_clk_i) begin
				if (sys_rst_i) begin
					run_mask_q[gi] <= 1'b0;
				end else if (mask_take) begin
					run_mask_q[gi] <= !hold_q[gi];
				end
			end
			always_ff @(posedge core_clk_i) begin
				if (sys_rst_i) begin
					ch_run_q[gi] <= 1'b0;
				end else if (mask_take) begin
					ch_run_q[gi] <= !hold_q[gi] && run_next;
				end else begin
					ch_run_q[gi] <= run_mask_q[gi] && run_next;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			duty_hold_q <= 1'b0;
			pwm_halt_q <= 1'b1;
			stage_reset_q <= 1'b0;
		end else begin
			duty_hold_q <= state_d == ST_RAMP_UP ||
				state_d == ST_RAMP_DN;
			pwm_halt_q <= state_d == ST_SHUT ||
				state_d == ST_FAULT;
			stage_reset_q <= state_d == ST_FAULT;
		end
	end
	assign stage_o = '{
		ch_run: ch_run_q,
		duty_hold: duty_hold_q,
		pwm_halt: pwm_halt_q,
		stage_reset: stage_reset_q
	};

	assign osc_factory_trim_o = !trim_sel_q;
	assign osc_trim_done_o = trim_done_q;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	AST_HOLD_RESET: assert property (
		$fell(sys_rst_i) |-> hold_q == HOLD_RST)
		else $error("hold group not at reset value");
	AST_EXIT_MASK: assert property (
		state_q == ST_SHUT && !sd_req && !backend_fault_i |=>
		run_mask_q == ~$past(hold_q[NUM_CH-1:0]) &&
		stage_o.ch_run == run_mask_q)
		else $error("started channels differ from hold group");
	AST_NO_HOLD_ZERO: assert property (
		state_q == ST_SHUT && !sd_req && ss_zero && !backend_fault_i
		##1 !sd_req && !backend_fault_i |-> state_q == ST_RAMP_UP ##1
		state_q == ST_RUN)
		else $error("zero period still held duty");
	AST_RAMP_LOAD: assert property (
		state_q == ST_SHUT && !sd_req && !ss_zero && !backend_fault_i |=>
		remain_q == psr_ss_ticks($past(ss_q[4:0])) && stage_o.duty_hold)
		else $error("start interval not loaded");
	AST_TIMER_DIS: assert property (
		state_q == ST_RUN && sd_req && ss_q[SS_DIS_BIT] && !backend_fault_i
		##1 !backend_fault_i |-> ##1 state_q == ST_SHUT)
		else $error("disabled timer still delayed stop");
	AST_TRIM_START: assert property (
		wr_trim && reg_req_i.wdata == TRIM_START |=>
		osc_factory_trim_o && !osc_trim_done_o && trim_busy_q)
		else $error("factory trim not started");
	AST_TRIM_DONE: assert property (
		$rose(trim_done_q) |-> $past(trim_busy_q) && !trim_sel_q)
		else $error("trim done without trim run");
	AST_FAULT_HALT: assert property (
		backend_fault_i && state_q != ST_SHUT |=> state_q == ST_FAULT &&
		stage_o.stage_reset && stage_o.pwm_halt && stage_o.ch_run == '0)
		else $error("back-end fault did not halt stage");
	AST_FAULT_LOAD: assert property (
		state_q != ST_FAULT && state_d == ST_FAULT |=>
		remain_q == psr_bk_ticks($past(bk_code_q)))
		else $error("recovery period not loaded");
	AST_RESTART: assert property (
		state_q == ST_FAULT && remain_q == '0 && !sd_req &&
		!backend_fault_i |=> state_q == ST_RAMP_UP && !stage_o.stage_reset)
		else $error("no restart after recovery wait");
	AST_BK_ONCE: assert property (
		bk_written_q && wr_bk |=> $stable(bk_code_q))
		else $error("recovery register written twice");
	AST_SD_ENTER: assert property (
		state_q == ST_RUN && sys_sd_q && !backend_fault_i |=>
		state_q == ST_RAMP_DN)
		else $error("shutdown command ignored");
	AST_PIN_STOP: assert property (
		state_q == ST_RUN && pin_change && power_down_pin_i &&
		!backend_fault_i |=> state_q == ST_RAMP_DN && stage_o.duty_hold)
		else $error("power-down pin edge did not start the stop ramp");

	COV_START: cover property (state_q == ST_RAMP_UP ##1 state_q == ST_RUN);
	COV_STOP: cover property (state_q == ST_RAMP_DN ##1 state_q == ST_SHUT);
	COV_FAULT: cover property (state_q == ST_FAULT ##1 state_q == ST_RAMP_UP);
	COV_TRIM: cover property ($rose(trim_done_q));
endmodule
`default_nettype wire

// ### tb/psr_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
module psr_stage_model (
	input wire logic core_clk_i, // core clock
	input wire logic fault_cmd_i, // bench asks for a back-end error
	input wire psr_pkg::psr_stage_t stage_i, // stage control from block
	output logic backend_fault_o // back-end error level
);
	import psr_pkg::*;
	logic err_q = 1'b0;
	// error latches until the block resets the stage, then clears
	always_ff @(posedge core_clk_i) begin
		if (stage_i.stage_reset)
			err_q <= 1'b0;
		else if (fault_cmd_i)
			err_q <= 1'b1;
	end
	assign backend_fault_o = err_q;
endmodule
`default_nettype wire

// ### tb/test_pwm_start_stop_recovery_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_pwm_start_stop_recovery_control;
	import psr_pkg::*;
	localparam int unsigned TK = 4;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	psr_reg_req_t req = '0;
	logic [7:0] rdata;
	logic pin = 1'b0;
	logic fault;
	logic fault_cmd = 1'b0;
	psr_stage_t stg;
	logic ftrim;
	logic tdone;
	logic [7:0] exp_q[$];
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	logic [31:0] rs = 32'd74942;
	logic [3:0] grp;
	always #4 core_clk_i = ~core_clk_i;
	psr_seq #(.TICK_CYC(TK), .TRIM_CYC(3)) u_dut (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.reg_req_i(req),
		.reg_rdata_o(rdata),
		.power_down_pin_i(pin),
		.backend_fault_i(fault),
		.stage_o(stg),
		.osc_factory_trim_o(ftrim),
		.osc_trim_done_o(tdone)
	);
	psr_stage_model u_stage (
		.core_clk_i(core_clk_i),
		.fault_cmd_i(fault_cmd),
		.stage_i(stg),
		.backend_fault_o(fault)
	);
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	task automatic close_out();
		$display("counts cmp %0d err %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("FAIL %s exp %h got %h", what, e, s);
		end
	endtask
	task automatic chk_rng(input string what, input int lo, input int hi,
		input int s);
		cmp_count++;
		if (s < lo || s > hi) begin
			error_cnt++;
			$display("FAIL %s exp %0d..%0d got %0d", what, lo, hi, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge core_clk_i);
		req = '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(negedge core_clk_i);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge core_clk_i);
		req = '0;
	endtask
	// counts cycles until hold (sel 0) or stage reset (sel 1) reaches lvl
	task automatic wait_on(input int sel, input logic lvl, output int cnt);
		cnt = 0;
		do begin
			@(negedge core_clk_i);
			cnt++;
		end while (((sel == 0) ? stg.duty_hold : stg.stage_reset) !== lvl
			&& cnt < 70000);
	endtask
	// read data lands at the taking edge; look at the following fall
	always @(posedge core_clk_i) begin
		if (req.rd) begin
			@(negedge core_clk_i);
			chk("rdata", exp_q.pop_front(), rdata);
		end
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			$display("FAIL timeout exp done got hang");
			close_out();
		end
	end
	initial begin
		repeat (6) @(negedge core_clk_i);
		sys_rst_i = 1'b0;
		chk("halt_rst", 8'h01, 8'(stg.pwm_halt));
		chk("ch_rst", 8'h00, 8'(stg.ch_run));
		rd(HOLD_ADDR, HOLD_RST);
		rd(SS_ADDR, SS_RST);
		rd(TRIM_ADDR, 8'h82);
		rd(BKND_ADDR, {4'h0, BK_RST});
		rd(SYS_CTRL2_ADDR, 8'h40);
		rd(8'h33, UNMAPPED_RD);
		$display("test reset values done");
		rs = xs(rs);
		grp = rs[3:0];
		wr(SS_ADDR, 8'h8f);
		wr(HOLD_ADDR, {4'h3, grp});
		rd(HOLD_ADDR, {4'h3, grp});
		wr(SYS_CTRL2_ADDR, 8'h00);
		wait_on(0, 1'b1, n);
		chk("ch_grp", {4'h0, ~grp}, 8'(stg.ch_run));
		wait_on(0, 1'b0, n);
		chk_rng("timer_off", 1, 1, n);
		chk("run_halt", 8'h00, 8'(stg.pwm_halt));
		wr(SYS_CTRL2_ADDR, 8'h40);
		wait_on(0, 1'b1, n);
		chk("ch_dn", {4'h0, ~grp}, 8'(stg.ch_run));
		wait_on(0, 1'b0, n);
		chk_rng("timer_dn", 1, 1, n);
		chk("halt_sd", 8'h01, 8'(stg.pwm_halt));
		chk("ch_sd", 8'h00, 8'(stg.ch_run));
		wr(SS_ADDR, 8'h05);
		wr(SYS_CTRL2_ADDR, 8'h00);
		wait_on(0, 1'b1, n);
		wait_on(0, 1'b0, n);
		chk_rng("no_hold", 1, 1, n);
		wr(SYS_CTRL2_ADDR, 8'h40);
		wait_on(0, 1'b1, n);
		wait_on(0, 1'b0, n);
		chk_rng("no_hold_dn", 1, 1, n);
		$display("test hold group done");
		wr(SS_ADDR, 8'h08);
		wr(HOLD_ADDR, HOLD_PARALLEL_BRIDGE_OUTPUT);
		wr(SYS_CTRL2_ADDR, 8'h00);
		wait_on(0, 1'b1, n);
		chk("ch_parallel_bridge_output", 8'h05, 8'(stg.ch_run));
		wait_on(0, 1'b0, n);
		chk_rng("ramp_up", 656, 665, n);
		@(negedge core_clk_i);
		pin = 1'b1;
		wait_on(0, 1'b1, n);
		wait_on(0, 1'b0, n);
		chk_rng("pin_dn", 656, 665, n);
		chk("pin_halt", 8'h01, 8'(stg.pwm_halt));
		pin = 1'b0;
		wait_on(0, 1'b1, n);
		wait_on(0, 1'b0, n);
		$display("test start stop period done");
		wr(BKND_ADDR, 8'h01);
		wr(BKND_ADDR, 8'h03);
		wr(BKND_ADDR, 8'h09);
		rd(BKND_ADDR, 8'h03);
		@(negedge core_clk_i);
		fault_cmd = 1'b1;
		@(negedge core_clk_i);
		fault_cmd = 1'b0;
		wait_on(1, 1'b1, n);
		chk("flt_halt", 8'h01, 8'(stg.pwm_halt));
		chk("flt_ch", 8'h00, 8'(stg.ch_run));
		wait_on(1, 1'b0, n);
		chk_rng("recover", 17950, 17975, n);
		chk("restart", 8'h01, 8'(stg.duty_hold));
		chk("re_ch", 8'h05, 8'(stg.ch_run));
		$display("test back-end recovery done");
		chk("ftrim0", 8'h00, 8'(ftrim));
		wr(TRIM_ADDR, TRIM_START);
		chk("ftrim", 8'h01, 8'(ftrim));
		chk("busy", 8'h00, 8'(tdone));
		repeat (6) @(negedge core_clk_i);
		chk("done", 8'h01, 8'(tdone));
		rd(TRIM_ADDR, 8'hc0);
		wr(TRIM_ADDR, 8'h42);
		rd(TRIM_ADDR, 8'h82);
		$display("test trim done");
		sys_rst_i = 1'b1;
		@(negedge core_clk_i);
		sys_rst_i = 1'b0;
		wr(BKND_ADDR, 8'h05);
		rd(BKND_ADDR, 8'h05);
		repeat (3) @(negedge core_clk_i);
		$display("test write once after reset done");
		close_out();
	end
endmodule
`default_nettype wire
